/* design/pmrbc_mdio_slave.sv */
// module: management frame receiver and read-data driver
`timescale 1ns/1ps
`default_nettype none
module pmrbc_mdio_slave
   import pmrbc_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // management pins
   input  wire logic              mdc_i,
   input  wire logic              mdio_i,
   output logic                   mdio_o,
   output logic                   mdio_oe_n_o,
   // settings from the bank
   input  wire logic [ADDR_W-1:0] my_strapped_phy_address_i,
   input  wire logic              no_preamble_i,
   // register access
   output logic [ADDR_W-1:0]      reg_addr_o,
   input  wire logic [DATA_W-1:0] rd_data_i,
   output logic                   wr_stb_o,
   output logic [DATA_W-1:0]      wr_data_o
);
   pmrbc_state_type   state_r;
   logic              mdc_d_r;
   logic              rise;
   logic [5:0]        ones_r;
   logic [4:0]        cnt_r;
   logic [DATA_W-1:0] sh_r;
   logic              is_read_r;
   logic [4:0]        field5;

   assign rise = mdc_i & ~mdc_d_r;
   assign field5 = {sh_r[3:0], mdio_i};

   // tracks the pin through reset, no false rise from an idle-high clock
   always_ff @(posedge ref_clk_i) begin
      mdc_d_r <= mdc_i;
   end

   // frame decode on each rising management clock
   always_ff @(posedge ref_clk_i) begin
      wr_stb_o <= 1'b0;
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         ones_r <= 6'h00;
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         is_read_r <= 1'b0;
         reg_addr_o <= 5'h00;
         wr_data_o <= 16'h0000;
      end else if (rise) begin
         cnt_r <= cnt_r + 5'h01;
         sh_r <= {sh_r[14:0], mdio_i};
         case (state_r)
            ST_IDLE: begin
               cnt_r <= 5'h00;
               if (mdio_i) ones_r <= (ones_r == PRE_ONES) ? ones_r : ones_r + 6'h01;
               else begin
                  ones_r <= 6'h00;
                  if (ones_r == PRE_ONES || no_preamble_i) state_r <= ST_SOF;
               end
            end
            ST_SOF: begin
               cnt_r <= 5'h00;
               state_r <= mdio_i ? ST_OPC : ST_IDLE;
            end
            ST_OPC: if (cnt_r == 5'h01) begin
               cnt_r <= 5'h00;
               is_read_r <= ({sh_r[0], mdio_i} == OP_RD);
               if ({sh_r[0], mdio_i} == OP_RD || {sh_r[0], mdio_i} == OP_WR) state_r <= ST_PHY;
               else state_r <= ST_IDLE;
            end
            ST_PHY: if (cnt_r == 5'h04) begin
               cnt_r <= 5'h00;
               if (field5 == 5'h00 || field5 == my_strapped_phy_address_i) state_r <= ST_REG;
               else state_r <= ST_IDLE;
            end
            ST_REG: if (cnt_r == 5'h04) begin
               cnt_r <= 5'h00;
               reg_addr_o <= field5;
               state_r <= ST_TA;
            end
            ST_TA: if (cnt_r == 5'h01) begin
               cnt_r <= 5'h00;
               state_r <= ST_DATA;
               if (is_read_r) sh_r <= rd_data_i;
            end
            ST_DATA: begin
               if (is_read_r) sh_r <= {sh_r[14:0], 1'b0};
               if (cnt_r == 5'h0f) begin
                  state_r <= ST_IDLE;
                  wr_stb_o <= ~is_read_r;
                  wr_data_o <= {sh_r[14:0], mdio_i};
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pin driver for read frames
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mdio_o <= 1'b1;
         mdio_oe_n_o <= 1'b1;
      end else if (rise && is_read_r) begin
         if (state_r == ST_TA && cnt_r == 5'h00) begin
            mdio_o <= 1'b0;
            mdio_oe_n_o <= 1'b0;
         end else if (state_r == ST_TA) mdio_o <= rd_data_i[15];
         else if (state_r == ST_DATA && cnt_r != 5'h0f) mdio_o <= sh_r[14];
         else if (state_r == ST_DATA) begin
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* design/pmrbc_pkg.sv */
// package: constants for the management register bank
package pmrbc_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned NUM_REGS = 32;
   // register addresses
   localparam logic [4:0] A_CTRL  = 5'h00;
   localparam logic [4:0] A_STAT  = 5'h01;
   localparam logic [4:0] A_ID_HI = 5'h02;
   localparam logic [4:0] A_ID_LO = 5'h03;
   localparam logic [4:0] A_ADV   = 5'h04;
   localparam logic [4:0] A_LPA   = 5'h05;
   localparam logic [4:0] A_EXP   = 5'h06;
   localparam logic [4:0] A_NPTX  = 5'h07;
   localparam logic [4:0] A_IMASK = 5'h10;
   localparam logic [4:0] A_ISTAT = 5'h11;
   localparam logic [4:0] A_DISC  = 5'h12;
   localparam logic [4:0] A_FCAR  = 5'h13;
   localparam logic [4:0] A_SKEY  = 5'h14;
   localparam logic [4:0] A_RXERR = 5'h15;
   localparam logic [4:0] A_DKEY  = 5'h16;
   localparam logic [4:0] A_CSL   = 5'h17;
   localparam logic [4:0] A_LBE   = 5'h18;
   localparam logic [4:0] A_SELF  = 5'h19;
   localparam logic [4:0] A_TSTAT = 5'h1b;
   localparam logic [4:0] A_TCFG  = 5'h1c;
   // control word bit positions
   localparam int unsigned B_SWRST   = 15;
   localparam int unsigned B_LOOP    = 14;
   localparam int unsigned B_SPEED   = 13;
   localparam int unsigned B_ANEN    = 12;
   localparam int unsigned B_PDOWN   = 11;
   localparam int unsigned B_ISO     = 10;
   localparam int unsigned B_RESTART = 9;
   localparam int unsigned B_DUPLEX  = 8;
   localparam int unsigned B_COLTEST = 7;
   // fields in other words
   localparam int unsigned CSL_NOPRE_BIT   = 9;
   localparam int unsigned TCFG_COMPAT_BIT = 5;
   // reset values
   localparam logic [15:0] RST_RW = 16'h0000;
   localparam logic [6:0]  RST_CTRL_LOW = 7'h00;
   // timing
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned RECAL_NS = 1000;
   localparam int unsigned RECAL_CYC = (RECAL_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] PRE_ONES = 6'h20;
   // frame opcodes
   localparam logic [1:0] OP_RD = 2'b10;
   localparam logic [1:0] OP_WR = 2'b01;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SOF  = 3'b001,
      ST_OPC  = 3'b011,
      ST_PHY  = 3'b010,
      ST_REG  = 3'b110,
      ST_TA   = 3'b111,
      ST_DATA = 3'b101
   } pmrbc_state_type;
endpackage

/* design/pmrbc_register_bank.sv */
// module: management register bank with basic mode control
// Notes on behaviour
// [R1] 16-bit words, reached only over management link
// [R2] addresses 0h-7h hold the standard set
// [R3] 8h-Fh, 1Ah, 1Dh-1Fh are reserved
// [R4] interrupt mask writable, interrupt status read-only
// [R5] the three event counters are read-only
// [R6] scrambler and descrambler keys are read/write
// [R7] 17h,18h,19h,1Ch writable; 1Bh read-only
// [R8] bit 15 write resets chip, self-clears
// [R9] bit 15 reads one during mode recalibration
// [R10] bit 14 loops transmit data to receive
// [R11] loopback pin sets bit 14, release clears
// [R12] bit 13 picks speed unless autoneg on
// [R13] bits 13,12 reset to autoneg strap state
// [R14] bit 12 enables autoneg, overrides 13 and 8
// [R15] bit 11 powers down, resets to zero
// [R16] compatibility bit freezes and disables bit 11
// [R17] bit 10 isolates MII data path
// [R18] bit 10 reset from address strap, isolate strap
// [R19] reserved reads zero, writes dropped
`timescale 1ns/1ps
`default_nettype none
module pmrbc_register_bank
   import pmrbc_pkg::*;
#(
   parameter logic [15:0] ID_HIGH      = 16'h0a5a, // arbitrary value
   parameter logic [15:0] ID_LOW       = 16'h5a01, // arbitrary value
   parameter int unsigned RECAL_CYCLES = RECAL_CYC
)
(
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // management link
   input  wire logic              mdc_i,
   input  wire logic              mdio_i,
   output logic                   mdio_o,
   output logic                   mdio_oe_n_o,
   // straps and control pins
   input  wire logic [1:0]        autoneg_strap_pins_i,
   input  wire logic              isolate_default_strap_i,
   input  wire logic [4:0]        strapped_phy_address_i,
   input  wire logic              loopback_request_pin_i,
   // state from the transceiver
   input  wire logic              an_started_i,
   input  wire logic              an_speed_100_i,
   input  wire logic              an_full_duplex_i,
   input  wire logic [DATA_W-1:0] status_word_i,
   input  wire logic [DATA_W-1:0] partner_ability_i,
   input  wire logic [DATA_W-1:0] expansion_i,
   input  wire logic [DATA_W-1:0] irq_status_i,
   input  wire logic [DATA_W-1:0] disconnect_count_i,
   input  wire logic [DATA_W-1:0] false_carrier_count_i,
   input  wire logic [DATA_W-1:0] rx_error_count_i,
   input  wire logic [DATA_W-1:0] ten_status_i,
   // mode controls
   output logic                   chip_reset_o,
   output logic                   recal_busy_o,
   output logic                   loopback_o,
   output logic                   speed_100_o,
   output logic                   full_duplex_o,
   output logic                   autoneg_en_o,
   output logic                   autoneg_restart_o,
   output logic                   power_down_o,
   output logic                   isolate_o,
   output logic                   collision_test_o,
   // configuration words
   output logic [DATA_W-1:0]      adv_o,
   output logic [DATA_W-1:0]      next_page_o,
   output logic [DATA_W-1:0]      int_mask_o,
   output logic [DATA_W-1:0]      scr_key_o,
   output logic [DATA_W-1:0]      dscr_key_o,
   output logic [DATA_W-1:0]      coding_sublayer_cfg_o,
   output logic [DATA_W-1:0]      loop_bypass_cfg_o,
   output logic [DATA_W-1:0]      ten_cfg_o
);
   localparam int unsigned CW = $clog2(RECAL_CYCLES + 1);

   if (RECAL_CYCLES < 1 || RECAL_CYCLES > 65535) begin : g_bad_param
      $error("recalibration count out of range");
   end

   function automatic logic is_rw(input logic [4:0] a);
      case (a)
         A_ADV, A_NPTX, A_IMASK, A_SKEY, A_DKEY, A_CSL, A_LBE, A_SELF, A_TCFG: is_rw = 1'b1;
         default: is_rw = 1'b0;
      endcase
   endfunction

   function automatic logic is_reserved(input logic [4:0] a);
      is_reserved = (a >= 5'h08 && a <= 5'h0f) || a == 5'h1a || a >= 5'h1d;
   endfunction

   function automatic logic an_strap_en(input logic [1:0] s);
      an_strap_en = (s != 2'b00);
   endfunction

   logic [DATA_W-1:0] rw_r [NUM_REGS];
   logic [4:0]        eng_addr;
   logic [DATA_W-1:0] rd_data;
   logic              wr_stb;
   logic [DATA_W-1:0] wr_data;
   logic              ctrl_wr;
   logic              compat;
   logic [1:0]        an_cap_r;
   logic              iso_cap_r;
   logic [4:0]        strapped_phy_address_cap_r;
   logic [1:0]        an_src;
   logic [4:0]        strapped_phy_address_src;
   logic              anen_dflt;
   logic              iso_dflt;
   logic              soft_rst_r;
   logic [CW-1:0]     recal_cnt_r;
   logic              lb_pin_d_r;
   logic              lb_rise;
   logic              lb_fall;
   logic              loop_r;
   logic              speed_r;
   logic              anen_r;
   logic              pdown_r;
   logic              iso_r;
   logic              restart_r;
   logic              duplex_r;
   logic              coltest_r;
   logic              speed_nxt;
   logic              duplex_nxt;
   logic              out_valid_r;
   logic              mode_chg;
   logic [DATA_W-1:0] ctrl_word;

   // serial frame engine
   pmrbc_mdio_slave u_mdio (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .mdc_i         (mdc_i),
      .mdio_i        (mdio_i),
      .mdio_o        (mdio_o),
      .mdio_oe_n_o   (mdio_oe_n_o),
      .my_strapped_phy_address_i    (rw_r[A_SELF][4:0]),
      .no_preamble_i (rw_r[A_CSL][CSL_NOPRE_BIT]),
      .reg_addr_o    (eng_addr),
      .rd_data_i     (rd_data),
      .wr_stb_o      (wr_stb),
      .wr_data_o     (wr_data)
   );

   assign ctrl_wr = wr_stb && eng_addr == A_CTRL;
   assign compat = rw_r[A_TCFG][TCFG_COMPAT_BIT];

   // strap capture while reset is held
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         an_cap_r <= autoneg_strap_pins_i;
         iso_cap_r <= isolate_default_strap_i;
         strapped_phy_address_cap_r <= strapped_phy_address_i;
      end
   end

   assign an_src = rst_n_i ? an_cap_r : autoneg_strap_pins_i;
   assign strapped_phy_address_src = rst_n_i ? strapped_phy_address_cap_r : strapped_phy_address_i;
   assign anen_dflt = an_strap_en(an_src); // [R13]
   assign iso_dflt = (strapped_phy_address_src == 5'h00) | (rst_n_i ? iso_cap_r : isolate_default_strap_i); // [R18]

   // plain read/write words
   for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_word
      if (is_rw(5'(gi))) begin : g_rw
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i || soft_rst_r) rw_r[gi] <= (5'(gi) == A_SELF) ? {11'h000, strapped_phy_address_src} : RST_RW; // [R8]
            else if (wr_stb && eng_addr == 5'(gi)) rw_r[gi] <= wr_data; // [R2] [R4] [R6] [R7]
         end
      end else begin : g_ro
         assign rw_r[gi] = 16'h0000; // [R19]
      end
   end

   assign adv_o = rw_r[A_ADV];
   assign next_page_o = rw_r[A_NPTX];
   assign int_mask_o = rw_r[A_IMASK];
   assign scr_key_o = rw_r[A_SKEY];
   assign dscr_key_o = rw_r[A_DKEY];
   assign coding_sublayer_cfg_o = rw_r[A_CSL];
   assign loop_bypass_cfg_o = rw_r[A_LBE];
   assign ten_cfg_o = rw_r[A_TCFG];

   // soft reset pulse and recalibration timer
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) soft_rst_r <= 1'b0;
      else soft_rst_r <= ctrl_wr && wr_data[B_SWRST]; // [R8]
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) recal_cnt_r <= '0;
      else if ((ctrl_wr && wr_data[B_SWRST]) || mode_chg) recal_cnt_r <= CW'(RECAL_CYCLES); // [R8] [R9]
      else if (recal_cnt_r != '0) recal_cnt_r <= recal_cnt_r - CW'(1);
   end

   assign recal_busy_o = recal_cnt_r != '0;
   assign chip_reset_o = soft_rst_r;

   // loopback pin edges
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) lb_pin_d_r <= 1'b0;
      else lb_pin_d_r <= loopback_request_pin_i;
   end

   assign lb_rise = loopback_request_pin_i & ~lb_pin_d_r;
   assign lb_fall = ~loopback_request_pin_i & lb_pin_d_r;

   // control word bits
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || soft_rst_r) begin
         loop_r <= 1'b0;
         speed_r <= anen_dflt; // [R13]
         anen_r <= anen_dflt; // [R13]
         duplex_r <= ~anen_dflt;
         pdown_r <= 1'b0; // [R15]
         iso_r <= iso_dflt; // [R18]
         restart_r <= 1'b0;
         coltest_r <= 1'b0;
      end else begin
         if (lb_rise) loop_r <= 1'b1; // [R11]
         else if (lb_fall) loop_r <= 1'b0; // [R11]
         else if (ctrl_wr) loop_r <= wr_data[B_LOOP];
         if (ctrl_wr) begin
            speed_r <= wr_data[B_SPEED];
            anen_r <= wr_data[B_ANEN]; // [R14]
            iso_r <= wr_data[B_ISO]; // [R17]
            duplex_r <= wr_data[B_DUPLEX];
            coltest_r <= wr_data[B_COLTEST];
         end
         if (ctrl_wr && !compat) pdown_r <= wr_data[B_PDOWN]; // [R15] [R16]
         if (ctrl_wr && wr_data[B_RESTART]) restart_r <= 1'b1;
         else if (an_started_i) restart_r <= 1'b0;
      end
   end

   assign speed_nxt = anen_r ? an_speed_100_i : speed_r; // [R12] [R14]
   assign duplex_nxt = anen_r ? an_full_duplex_i : duplex_r; // [R14]
   assign mode_chg = out_valid_r && ({speed_nxt, duplex_nxt, anen_r, loop_r}
                     != {speed_100_o, full_duplex_o, autoneg_en_o, loopback_o}); // [R9]

   // registered mode outputs
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         out_valid_r <= 1'b0;
         speed_100_o <= 1'b0;
         full_duplex_o <= 1'b0;
         autoneg_en_o <= 1'b0;
         loopback_o <= 1'b0;
         power_down_o <= 1'b0;
         isolate_o <= 1'b0;
         autoneg_restart_o <= 1'b0;
         collision_test_o <= 1'b0;
      end else begin
         out_valid_r <= 1'b1;
         speed_100_o <= speed_nxt; // [R12]
         full_duplex_o <= duplex_nxt;
         autoneg_en_o <= anen_r;
         loopback_o <= loop_r; // [R10]
         power_down_o <= pdown_r & ~compat; // [R15] [R16]
         isolate_o <= iso_r; // [R17]
         autoneg_restart_o <= restart_r;
         collision_test_o <= coltest_r;
      end
   end

   assign ctrl_word = {recal_busy_o | soft_rst_r, loop_r, speed_r, anen_r, pdown_r, iso_r, // [R9]
                       restart_r, duplex_r, coltest_r, RST_CTRL_LOW};

   // read multiplexer
   function automatic logic [DATA_W-1:0] rd_word(input logic [4:0] a);
      case (a)
         A_CTRL:  rd_word = ctrl_word;
         A_STAT:  rd_word = status_word_i; // [R2]
         A_ID_HI: rd_word = ID_HIGH;
         A_ID_LO: rd_word = ID_LOW;
         A_LPA:   rd_word = partner_ability_i;
         A_EXP:   rd_word = expansion_i;
         A_ISTAT: rd_word = irq_status_i; // [R4]
         A_DISC:  rd_word = disconnect_count_i; // [R5]
         A_FCAR:  rd_word = false_carrier_count_i; // [R5]
         A_RXERR: rd_word = rx_error_count_i; // [R5]
         A_TSTAT: rd_word = ten_status_i; // [R7]
         default: rd_word = rw_r[a]; // [R3] [R19]
      endcase
   endfunction

   assign rd_data = rd_word(eng_addr); // [R1]

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_soft_write;
      ctrl_wr && wr_data[B_SWRST];
   endsequence
   sequence s_reset_then_busy;
      chip_reset_o && recal_busy_o ##1 recal_busy_o && ctrl_word[B_SWRST];
   endsequence

   AST_SOFT_RESET: assert property (s_soft_write |=> s_reset_then_busy) // [R8]
      else $error("soft reset did not start recalibration");
   AST_SOFT_DEFAULTS: assert property (chip_reset_o |=> !pdown_r && !coltest_r && anen_r == an_strap_en(an_cap_r)) // [R8]
      else $error("soft reset did not restore defaults");
   AST_MODE_BUSY: assert property (mode_chg |=> recal_busy_o && ctrl_word[B_SWRST]) // [R9]
      else $error("mode change did not show busy");
   AST_LB_PIN_SET: assert property ($rose(loopback_request_pin_i) |=> ##1 loopback_o) // [R11]
      else $error("loopback pin did not set loopback");
   AST_LB_PIN_CLR: assert property ($fell(loopback_request_pin_i) && !soft_rst_r |=> ##1 !loopback_o) // [R11]
      else $error("loopback pin release did not clear loopback");
   AST_FORCED_SPEED: assert property (!anen_r |=> speed_100_o == $past(speed_r)) // [R12]
      else $error("forced speed not applied");
   AST_AUTONEG_WINS: assert property (anen_r |=> speed_100_o == $past(an_speed_100_i)
                                      && full_duplex_o == $past(an_full_duplex_i)) // [R14]
      else $error("autoneg result not applied");
   AST_PDOWN_FROZEN: assert property (compat && ctrl_wr |=> pdown_r == $past(pdown_r)) // [R16]
      else $error("power down changed in compatibility mode");
   AST_PDOWN_SET: assert property (!compat && ctrl_wr && wr_data[B_PDOWN] && !wr_data[B_SWRST] && !soft_rst_r
                                   |=> ##1 power_down_o || compat) // [R15]
      else $error("power down not entered");
   AST_RESERVED_ZERO: assert property (is_reserved(eng_addr) |-> rd_data == 16'h0000) // [R19]
      else $error("reserved address read nonzero");
   AST_ISO_RESET: assert property ($rose(rst_n_i) |-> iso_r == (strapped_phy_address_cap_r == 5'h00 || iso_cap_r)) // [R18]
      else $error("isolate reset value wrong");
   AST_RW_READBACK: assert property (wr_stb && is_rw(eng_addr) && !soft_rst_r
                                     |=> rd_word($past(eng_addr)) == $past(wr_data)) // [R6]
      else $error("written word not read back");
endmodule
`default_nettype wire

/* testbench/pmrbc_mac_model.sv */
// station manager model driving the management clock and data line
`timescale 1ns/1ps
`default_nettype none
module pmrbc_mac_model (
   // clock
   input  wire logic clk_i,
   // management pins
   output logic      mdc_o,
   output logic      mdio_o,
   input  wire logic phy_mdio_i,
   input  wire logic phy_oe_n_i
);
   logic drv_en;
   logic drv;
   // pull-up holds the line high when nobody drives
   assign mdio_o = !phy_oe_n_i ? phy_mdio_i : (drv_en ? drv : 1'b1);
   initial begin
      mdc_o = 1'b0;
      drv_en = 1'b0;
      drv = 1'b1;
   end
   // one bit time: low half, sample, rising edge
   task automatic bit_t(input logic en, input logic b, output logic s);
      @(posedge clk_i);
      #1;
      mdc_o = 1'b0;
      drv_en = en;
      drv = b;
      repeat (2) @(posedge clk_i);
      #1;
      s = mdio_o;
      mdc_o = 1'b1;
      @(posedge clk_i);
   endtask
   // whole frame to phy address zero, 16-bit word msb first
   task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic        s;
      hdr = {2'b01, (wr ? 2'b01 : 2'b10), 5'h00, ra};
      for (int i = 0; i < 32; i++) bit_t(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_t(1'b1, hdr[i], s);
      bit_t(wr, 1'b1, s);
      bit_t(wr, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_t(wr, wd[i], s);
         rd[i] = s;
      end
      bit_t(1'b0, 1'b1, s);
   endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pmrbc_pkg::*;
   localparam int unsigned RCY = 400;
   logic ref_clk_i, rst_n_i, mdc_i, mdio_i, mdio_o, mdio_oe_n_o;
   logic [1:0] autoneg_strap_pins_i;
   logic [4:0] strapped_phy_address_i;
   logic isolate_default_strap_i, loopback_request_pin_i, an_started_i, an_speed_100_i, an_full_duplex_i;
   logic [DATA_W-1:0] status_word_i, partner_ability_i, expansion_i, irq_status_i, disconnect_count_i;
   logic [DATA_W-1:0] false_carrier_count_i, rx_error_count_i, ten_status_i;
   logic chip_reset_o, recal_busy_o, loopback_o, speed_100_o, full_duplex_o, autoneg_en_o;
   logic autoneg_restart_o, power_down_o, isolate_o, collision_test_o;
   logic [DATA_W-1:0] adv_o, next_page_o, int_mask_o, scr_key_o, dscr_key_o;
   logic [DATA_W-1:0] coding_sublayer_cfg_o, loop_bypass_cfg_o, ten_cfg_o;
   logic [15:0] rd;
   int error_cnt, checked, pulses;
   logic [4:0] rw_a [8] = '{A_ADV, A_NPTX, A_IMASK, A_SKEY, A_DKEY, A_CSL, A_LBE, A_TCFG};
   logic [4:0] ro_a [8] = '{A_STAT, A_LPA, A_EXP, A_ISTAT, A_DISC, A_FCAR, A_RXERR, A_TSTAT};
   logic [4:0] rs_a [5] = '{5'h08, 5'h0f, 5'h1a, 5'h1d, 5'h1f};
   // id values are arbitrary
   pmrbc_register_bank #(.ID_HIGH(16'h1234), .ID_LOW(16'h4321), .RECAL_CYCLES(RCY)) dut (
      .ref_clk_i, .rst_n_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_n_o, .autoneg_strap_pins_i,
      .isolate_default_strap_i, .strapped_phy_address_i, .loopback_request_pin_i, .an_started_i,
      .an_speed_100_i, .an_full_duplex_i, .status_word_i, .partner_ability_i, .expansion_i, .irq_status_i,
      .disconnect_count_i, .false_carrier_count_i, .rx_error_count_i, .ten_status_i, .chip_reset_o,
      .recal_busy_o, .loopback_o, .speed_100_o, .full_duplex_o, .autoneg_en_o, .autoneg_restart_o,
      .power_down_o, .isolate_o, .collision_test_o, .adv_o, .next_page_o, .int_mask_o, .scr_key_o,
      .dscr_key_o, .coding_sublayer_cfg_o, .loop_bypass_cfg_o, .ten_cfg_o);
   pmrbc_mac_model mac (.clk_i(ref_clk_i), .mdc_o(mdc_i), .mdio_o(mdio_i), .phy_mdio_i(mdio_o),
      .phy_oe_n_i(mdio_oe_n_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(negedge ref_clk_i) if (chip_reset_o === 1'b1) pulses++;
   task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      mac.xfer(1'b1, a, d, rd);
      #1;
   endtask
   task automatic rdr(input logic [4:0] a);
      mac.xfer(1'b0, a, 16'h0000, rd);
      #1;
   endtask
   task automatic do_reset(input logic [1:0] an, input logic [4:0] pa, input logic iso);
      @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b0;
      autoneg_strap_pins_i = an;
      strapped_phy_address_i = pa;
      isolate_default_strap_i = iso;
      repeat (16) @(posedge ref_clk_i);
      #1 rst_n_i = 1'b1;
   endtask
   task automatic t_reset;
      do_reset(2'b01, 5'h03, 1'b0);
      rdr(A_CTRL);
      cmp("ctrl", 16'h3000, rd);
      cmp("anen", 16'h0001, {15'h0, autoneg_en_o});
      do_reset(2'b00, 5'h00, 1'b0);
      rdr(A_CTRL);
      cmp("ctrl", 16'h0500, rd);
      cmp("iso", 16'h0001, {15'h0, isolate_o});
      $display("test reset done");
   endtask
   task automatic t_map;
      foreach (rw_a[i]) begin
         wr(rw_a[i], 16'ha5c3 ^ rw_a[i]);
         rdr(rw_a[i]);
         cmp("rw", 16'ha5c3 ^ rw_a[i], rd);
      end
      cmp("adv", 16'ha5c7, adv_o);
      cmp("npg", 16'ha5c4, next_page_o);
      cmp("imask", 16'ha5d3, int_mask_o);
      cmp("skey", 16'ha5d7, scr_key_o);
      cmp("dkey", 16'ha5d5, dscr_key_o);
      cmp("csl", 16'ha5d4, coding_sublayer_cfg_o);
      cmp("lbe", 16'ha5db, loop_bypass_cfg_o);
      cmp("tcfg", 16'ha5df, ten_cfg_o);
      foreach (ro_a[i]) begin
         wr(ro_a[i], 16'hffff);
         rdr(ro_a[i]);
         cmp("ro", {11'h608, ro_a[i]}, rd);
      end
      rdr(A_ID_HI);
      cmp("idh", 16'h1234, rd);
      foreach (rs_a[i]) begin
         wr(rs_a[i], 16'hffff);
         rdr(rs_a[i]);
         cmp("rsv", 16'h0000, rd);
      end
      $display("test map done");
   endtask
   task automatic t_soft;
      wr(A_ADV, 16'h01e1);
      pulses = 0;
      wr(A_CTRL, 16'h8500);
      rdr(A_CTRL);
      cmp("ctrl", 16'h8500, rd);
      cmp("pulse", 16'h0001, pulses[15:0]);
      repeat (RCY) @(posedge ref_clk_i);
      rdr(A_CTRL);
      cmp("ctrl", 16'h0500, rd);
      rdr(A_ADV);
      cmp("adv", 16'h0000, rd);
      $display("test soft done");
   endtask
   task automatic t_loop;
      loopback_request_pin_i = 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1 cmp("lb", 16'h0001, {15'h0, loopback_o});
      cmp("busy", 16'h0001, {15'h0, recal_busy_o});
      rdr(A_CTRL);
      cmp("ctrl", 16'hc500, rd);
      loopback_request_pin_i = 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1 cmp("lb", 16'h0000, {15'h0, loopback_o});
      repeat (RCY) @(posedge ref_clk_i);
      wr(A_CTRL, 16'h4400);
      cmp("lb", 16'h0001, {15'h0, loopback_o});
      wr(A_CTRL, 16'h0000);
      cmp("iso", 16'h0000, {15'h0, isolate_o});
      $display("test loop done");
   endtask
   task automatic t_speed;
      wr(A_CTRL, 16'h2000);
      cmp("spd", 16'h0001, {15'h0, speed_100_o});
      an_speed_100_i = 1'b1;
      wr(A_CTRL, 16'h1100);
      cmp("spd", 16'h0001, {15'h0, speed_100_o});
      cmp("fdx", 16'h0000, {15'h0, full_duplex_o});
      an_speed_100_i = 1'b0;
      wr(A_CTRL, 16'h3000);
      cmp("spd", 16'h0000, {15'h0, speed_100_o});
      wr(A_CTRL, 16'h0000);
      $display("test speed done");
   endtask
   task automatic t_pd;
      wr(A_TCFG, 16'h0000);
      wr(A_CTRL, 16'h0800);
      cmp("pd", 16'h0001, {15'h0, power_down_o});
      wr(A_CTRL, 16'h0000);
      cmp("pd", 16'h0000, {15'h0, power_down_o});
      wr(A_TCFG, 16'h0020);
      wr(A_CTRL, 16'h0800);
      rdr(A_CTRL);
      cmp("ctrl", 16'h0000, rd & 16'h7fff);
      cmp("pd", 16'h0000, {15'h0, power_down_o});
      $display("test power done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      error_cnt++;
      wrap_up();
   end
   initial begin
      {error_cnt, checked, pulses} = '0;
      {rst_n_i, loopback_request_pin_i, an_started_i, an_speed_100_i, an_full_duplex_i} = '0;
      {status_word_i, partner_ability_i, expansion_i, irq_status_i} = 64'hc101_c105_c106_c111;
      {disconnect_count_i, false_carrier_count_i, rx_error_count_i, ten_status_i} = 64'hc112_c113_c115_c11b;
      t_reset();
      t_map();
      t_soft();
      t_loop();
      t_speed();
      t_pd();
      wrap_up();
   end
endmodule
`default_nettype wire
